// ### kil_pkg.sv
// constants shared by the keypad interrupt logic files
// assumes a byte-addressed avalon-mm slave with 32-bit data
package kil_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned PIN_COUNT = 5;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SYNC_STAGES = 2;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS_CONTROL = 6'h1a;
  localparam logic [5:0] IDX_PIN_ENABLE = 6'h1b;
  localparam logic [5:0] IDX_EVT_STATUS = 6'h1c;
  localparam logic [5:0] IDX_EVT_CLEAR = 6'h1d;
  localparam logic [5:0] IDX_EVT_ENABLE = 6'h1e;

  // status and control field positions
  localparam int unsigned BIT_SENSITIVITY = 0;
  localparam int unsigned BIT_MASK = 1;
  localparam int unsigned BIT_ACK = 2;
  localparam int unsigned BIT_PENDING = 3;

  // reset values
  localparam logic RST_SENSITIVITY = 1'b0;
  localparam logic RST_MASK = 1'b0;
  localparam logic [4:0] RST_PIN_ENABLE = 5'h00;
  localparam logic RST_PENDING = 1'b0;

  // event bits of the interrupt status register
  localparam int unsigned EVT_COUNT = 2;
  localparam int unsigned EVT_REQUEST = 0;
  localparam int unsigned EVT_RELEASE = 1;
  localparam logic [1:0] RST_EVT = 2'h0;

  // bus handshake states
  typedef enum logic [1:0] {
    KIL_BUS_IDLE = 2'b01,
    KIL_BUS_ACK = 2'b10
  } kil_bus_state_type;

endpackage

// ### kil_sync.sv
// two-flop synchroniser for a vector of pin levels
// assumes the inputs are asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
module kil_sync (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [kil_pkg::PIN_COUNT-1:0] async_i,
  output logic [kil_pkg::PIN_COUNT-1:0] sync_o
);

  logic [kil_pkg::PIN_COUNT-1:0] stage1_reg;
  logic [kil_pkg::PIN_COUNT-1:0] stage2_reg;

  // pins idle high, so reset to all ones to avoid a false fall
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1_reg <= 5'h1f;
      stage2_reg <= 5'h1f;
    end else begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_o = stage2_reg;

endmodule
`default_nettype wire

// ### kil_irq_regs.sv
// sticky event status, enable and write-one-to-clear logic
// assumes event pulses and writes come from the core_clk_i domain
`timescale 1ns/1ps
`default_nettype none
module kil_irq_regs (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [kil_pkg::EVT_COUNT-1:0] event_i,
  input wire logic enable_we_i,
  input wire logic clear_we_i,
  input wire logic [kil_pkg::EVT_COUNT-1:0] wdata_i,
  output logic [kil_pkg::EVT_COUNT-1:0] status_o,
  output logic [kil_pkg::EVT_COUNT-1:0] enable_o,
  output logic irq_o
);

  logic [kil_pkg::EVT_COUNT-1:0] status_reg;
  logic [kil_pkg::EVT_COUNT-1:0] status_next;
  logic [kil_pkg::EVT_COUNT-1:0] enable_reg;
  logic [kil_pkg::EVT_COUNT-1:0] enable_next;
  logic irq_reg;
  logic irq_next;

  // a new event wins over a clear in the same cycle
  assign status_next = (status_reg & ~(clear_we_i ? wdata_i : 2'h0))
    | event_i;
  assign enable_next = enable_we_i ? wdata_i : enable_reg;
  assign irq_next = |(status_next & enable_next);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_reg <= kil_pkg::RST_EVT;
      enable_reg <= kil_pkg::RST_EVT;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
      irq_reg <= irq_next;
    end
  end

  assign status_o = status_reg;
  assign enable_o = enable_reg;
  assign irq_o = irq_reg;

endmodule
`default_nettype wire

// ### kil_top.sv
// keypad interrupt logic: five pins, pending latch, mask, acknowledge
// assumes pins are asynchronous, break and vector-fetch inputs are
// synchronous to core_clk_i, and an avalon-mm master with waitrequest
//
// How it works
// [RULE1] processor request drives only while pending and unmasked
// [RULE2] software masks, enables pins, acknowledges, then unmasks
// [RULE3] level mode: software delays acknowledge until pullups settle
// [RULE4] alternative: drive pins high as outputs before enabling
// [RULE5] logic keeps running in wait; unmasked request wakes cpu
// [RULE6] logic keeps running in stop; unmasked request wakes cpu
// [RULE7] break clear enabled: acknowledge works and flag stays cleared
// [RULE8] break clear disabled: acknowledge writes in break are ignored
// [RULE9] status bits seven to four read zero, writes ignored
// [RULE10] read-only pending flag shows latch; reset clears it
// [RULE11] acknowledge bit is write-one-to-clear and always reads zero
// [RULE12] mask bit read/write; set blocks requests; reset clears
// [RULE13] sensitivity bit: one edge and level, zero edge only
// [RULE14] per-pin enable bits; clear bit excludes pin; reset clears
// [RULE15] latch on first enabled low after all enabled high
// [RULE16] level mode clears after acknowledge and full release
// [RULE17] vector fetch acts exactly as an acknowledge write; here a fetch also acknowledges in break with break clear disabled
// [RULE18] edge mode clears at once on acknowledge or fetch
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module kil_top (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // avalon-mm slave
  input wire logic [kil_pkg::ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [kil_pkg::DATA_W-1:0] writedata_i,
  output logic [kil_pkg::DATA_W-1:0] readdata_o,
  output logic waitrequest_o,
  // keypad pins and processor side
  input wire logic [kil_pkg::PIN_COUNT-1:0] keypad_irq_pin_i,
  input wire logic vector_fetch_i,
  input wire logic break_active_i,
  input wire logic break_clear_enable_i,
  output logic keypad_irq_o,
  output logic wakeup_o,
  output logic irq_o
);

  // bus handshake
  kil_pkg::kil_bus_state_type bus_state_reg;
  kil_pkg::kil_bus_state_type bus_state_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [kil_pkg::DATA_W-1:0] readdata_reg;
  logic [kil_pkg::DATA_W-1:0] readdata_next;

  // control registers
  logic sensitivity_reg;
  logic sensitivity_next;
  logic mask_reg;
  logic mask_next;
  logic [kil_pkg::PIN_COUNT-1:0] pin_enable_reg;
  logic [kil_pkg::PIN_COUNT-1:0] pin_enable_next;

  // request latch
  logic pending_reg;
  logic pending_next;
  logic ack_seen_reg;
  logic ack_seen_next;
  logic any_low_reg;
  logic keypad_irq_reg;
  logic keypad_irq_next;
  logic wakeup_reg;

  // decode and datapath wires
  wire logic [kil_pkg::PIN_COUNT-1:0] pins_sync;
  wire logic [5:0] reg_index;
  wire logic bus_req;
  wire logic bus_commit;
  wire logic wr_commit;
  wire logic low_byte_we;
  wire logic sel_status;
  wire logic sel_enable;
  wire logic sel_evt_status;
  wire logic sel_evt_clear;
  wire logic sel_evt_enable;
  wire logic ack_write;
  wire logic ack_blocked;
  wire logic acknowledge;
  wire logic any_low;
  wire logic fall_event;
  wire logic release_event;
  wire logic [7:0] status_byte;
  wire logic [7:0] read_byte;
  wire logic [kil_pkg::EVT_COUNT-1:0] evt_status;
  wire logic [kil_pkg::EVT_COUNT-1:0] evt_enable;
  wire logic [kil_pkg::EVT_COUNT-1:0] evt_pulse;

  // select one register from the word index
  function automatic logic hit(input logic [5:0] idx,
                               input logic [5:0] want);
    hit = (idx == want);
  endfunction

  kil_sync u_sync (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(keypad_irq_pin_i),
    .sync_o(pins_sync)
  );

  assign reg_index = address_i[7:2];
  assign bus_req = read_i | write_i;
  // a request completes at the edge where waitrequest is seen low
  assign bus_commit = bus_req & ~waitrequest_reg;
  assign wr_commit = write_i & bus_commit;
  // all fields sit in the low byte lane
  assign low_byte_we = wr_commit & byteenable_i[0];

  assign sel_status = hit(reg_index, kil_pkg::IDX_STATUS_CONTROL);
  assign sel_enable = hit(reg_index, kil_pkg::IDX_PIN_ENABLE);
  assign sel_evt_status = hit(reg_index, kil_pkg::IDX_EVT_STATUS);
  assign sel_evt_clear = hit(reg_index, kil_pkg::IDX_EVT_CLEAR);
  assign sel_evt_enable = hit(reg_index, kil_pkg::IDX_EVT_ENABLE);

  // acknowledge sources
  assign ack_write = low_byte_we & sel_status
    & writedata_i[kil_pkg::BIT_ACK];
  // during break the write only counts when clearing is allowed
  assign ack_blocked = break_active_i & ~break_clear_enable_i; // [RULE8]
  // fetch has the same effect as a software write, but break never blocks a fetch
  assign acknowledge = (ack_write & ~ack_blocked) // [RULE7] [RULE11]
    | vector_fetch_i; // [RULE17]

  // only enabled pins take part
  assign any_low = |(~pins_sync & pin_enable_reg); // [RULE14]
  // first fall after every enabled pin was high
  assign fall_event = any_low & ~any_low_reg; // [RULE15]
  assign release_event = ~any_low & any_low_reg;

  // request latch; a new fall wins over a same-cycle acknowledge
  always_comb begin
    pending_next = pending_reg;
    ack_seen_next = ack_seen_reg;
    if (fall_event) begin
      pending_next = 1'b1; // [RULE15]
      ack_seen_next = 1'b0;
    end else if (pending_reg) begin
      if (!sensitivity_reg) begin
        // edge only: clear even while a pin is held low
        if (acknowledge) begin
          pending_next = 1'b0; // [RULE18]
        end
      end else begin
        // edge and level: acknowledge and release in any order
        if ((acknowledge || ack_seen_reg) && !any_low) begin
          pending_next = 1'b0; // [RULE16]
          ack_seen_next = 1'b0;
        end else if (acknowledge) begin
          ack_seen_next = 1'b1; // [RULE16]
        end
      end
    end else begin
      ack_seen_next = 1'b0;
    end
  end

  // pending shown regardless of mask; request to cpu only unmasked
  assign keypad_irq_next = pending_next & ~mask_next; // [RULE1] [RULE12]

  // control register writes
  assign sensitivity_next = (low_byte_we && sel_status)
    ? writedata_i[kil_pkg::BIT_SENSITIVITY] // [RULE13]
    : sensitivity_reg;
  assign mask_next = (low_byte_we && sel_status)
    ? writedata_i[kil_pkg::BIT_MASK] // [RULE12]
    : mask_reg;
  assign pin_enable_next = (low_byte_we && sel_enable)
    ? writedata_i[kil_pkg::PIN_COUNT-1:0] // [RULE14]
    : pin_enable_reg;

  // upper nibble and acknowledge always read zero
  assign status_byte = {4'h0, // [RULE9]
                        pending_reg, // [RULE10]
                        1'b0, // [RULE11]
                        mask_reg,
                        sensitivity_reg};

  assign read_byte = sel_status ? status_byte
    : sel_enable ? {3'h0, pin_enable_reg}
    : sel_evt_status ? {6'h00, evt_status}
    : sel_evt_enable ? {6'h00, evt_enable}
    : 8'h00;

  assign evt_pulse = {release_event, fall_event};

  kil_irq_regs u_irq (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .event_i(evt_pulse),
    .enable_we_i(low_byte_we & sel_evt_enable),
    .clear_we_i(low_byte_we & sel_evt_clear),
    .wdata_i(writedata_i[kil_pkg::EVT_COUNT-1:0]),
    .status_o(evt_status),
    .enable_o(evt_enable),
    .irq_o(irq_o)
  );

  // one wait cycle: data are captured at the same edge where waitrequest drops
  always_comb begin
    bus_state_next = bus_state_reg;
    waitrequest_next = 1'b1;
    readdata_next = readdata_reg;
    case (bus_state_reg)
      kil_pkg::KIL_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_next = kil_pkg::KIL_BUS_ACK;
          waitrequest_next = 1'b0;
          readdata_next = read_i ? {24'h000000, read_byte} : 32'h00000000;
        end
      end
      kil_pkg::KIL_BUS_ACK: begin
        bus_state_next = kil_pkg::KIL_BUS_IDLE;
        waitrequest_next = 1'b1;
      end
      default: begin
        bus_state_next = kil_pkg::KIL_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_state_reg <= kil_pkg::KIL_BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else begin
      bus_state_reg <= bus_state_next;
      waitrequest_reg <= waitrequest_next;
      readdata_reg <= readdata_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sensitivity_reg <= kil_pkg::RST_SENSITIVITY; // [RULE13]
      mask_reg <= kil_pkg::RST_MASK; // [RULE12]
      pin_enable_reg <= kil_pkg::RST_PIN_ENABLE; // [RULE14]
    end else begin
      sensitivity_reg <= sensitivity_next;
      mask_reg <= mask_next;
      pin_enable_reg <= pin_enable_next;
    end
  end

  // reset clears the request even with a pin held low
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pending_reg <= kil_pkg::RST_PENDING; // [RULE10]
      ack_seen_reg <= 1'b0;
      any_low_reg <= 1'b0;
      keypad_irq_reg <= 1'b0;
      wakeup_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
      ack_seen_reg <= ack_seen_next;
      any_low_reg <= any_low;
      keypad_irq_reg <= keypad_irq_next; // [RULE1]
      // wake needs this clock; no gating inside the block
      wakeup_reg <= keypad_irq_next; // [RULE5] [RULE6]
    end
  end

  assign readdata_o = readdata_reg;
  assign waitrequest_o = waitrequest_reg;
  assign keypad_irq_o = keypad_irq_reg;
  assign wakeup_o = wakeup_reg;

endmodule
`default_nettype wire

// ### kil_monitor.sv
// port checker for the keypad interrupt logic
// assumes kil_pkg compiled first and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module kil_monitor (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [kil_pkg::ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [kil_pkg::DATA_W-1:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic [kil_pkg::PIN_COUNT-1:0] keypad_irq_pin_i,
  input wire logic vector_fetch_i,
  input wire logic keypad_irq_o,
  input wire logic wakeup_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  wire rd_sc = read_i && !waitrequest_o &&
    address_i[7:2] == kil_pkg::IDX_STATUS_CONTROL;
  wire rd_pe = read_i && !waitrequest_o &&
    address_i[7:2] == kil_pkg::IDX_PIN_ENABLE;
  a_wake_follows_irq: assert property (wakeup_o == keypad_irq_o)
    else $error("wakeup differs from request");
  a_status_upper_zero: assert property (rd_sc |-> readdata_o[31:4] == '0)
    else $error("status upper bits not zero");
  a_ack_reads_zero: assert property (rd_sc |-> !readdata_o[2])
    else $error("acknowledge bit read as one");
  a_enable_upper_zero: assert property (rd_pe |-> readdata_o[31:5] == '0)
    else $error("enable register upper bits set");
  a_bus_answer: assert property ((read_i || write_i) && waitrequest_o
    |=> !waitrequest_o) else $error("no answer after one wait");
  a_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low too long");
  a_irq_has_cause: assert property ($rose(keypad_irq_o) |-> $past(write_i)
    || $past(write_i, 2) || !(&$past(keypad_irq_pin_i, 3)))
    else $error("request rose without a low pin");
  a_irq_drop_cause: assert property ($fell(keypad_irq_o) |-> $past(write_i)
    || $past(vector_fetch_i) || &$past(keypad_irq_pin_i, 3))
    else $error("request dropped without cause");
endmodule
bind kil_top kil_monitor u_mon (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .keypad_irq_pin_i(keypad_irq_pin_i),
  .vector_fetch_i(vector_fetch_i), .keypad_irq_o(keypad_irq_o),
  .wakeup_o(wakeup_o));
`default_nettype wire

// ### kil_keys.sv
// model of the key switches on the five keypad pins
// assumes pullups hold every released pin high
`timescale 1ns/1ps
`default_nettype none
module kil_keys (
  input wire logic [kil_pkg::PIN_COUNT-1:0] press_i,
  output logic [kil_pkg::PIN_COUNT-1:0] pin_o
);
  // released keys go to the pullup level, never left floating
  assign pin_o = ~press_i;
endmodule
`default_nettype wire

// ### kil_tb_top.sv
// self-checking bench for the keypad interrupt logic
// assumes kil_pkg, kil_top, kil_keys and kil_monitor are compiled
`timescale 1ns/1ps
`default_nettype none
module kil_tb_top;
  localparam logic [7:0] A_SC = {kil_pkg::IDX_STATUS_CONTROL, 2'b00};
  localparam logic [7:0] A_PE = {kil_pkg::IDX_PIN_ENABLE, 2'b00};
  localparam logic [7:0] A_ES = {kil_pkg::IDX_EVT_STATUS, 2'b00};
  localparam logic [7:0] A_EC = {kil_pkg::IDX_EVT_CLEAR, 2'b00};
  localparam logic [7:0] A_EE = {kil_pkg::IDX_EVT_ENABLE, 2'b00};
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic vf = 1'b0;
  logic brk = 1'b0;
  logic bce = 1'b0;
  logic [4:0] press = 5'h00;
  logic [4:0] pins;
  logic [31:0] readdata_o;
  logic waitrequest_o, keypad_irq_o, wakeup_o, irq_o;
  logic [31:0] q;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  always #20 core_clk_i = ~core_clk_i;
  kil_keys keys (.press_i(press), .pin_o(pins));
  kil_top dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .byteenable_i(4'h1), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .keypad_irq_pin_i(pins), .vector_fetch_i(vf),
    .break_active_i(brk), .break_clear_enable_i(bce),
    .keypad_irq_o(keypad_irq_o), .wakeup_o(wakeup_o), .irq_o(irq_o));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // data stands from the answer through the taking edge, so the
  // negedge before it sees the same value without a race
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    do begin
      @(negedge core_clk_i);
      q = readdata_o;
    end while (waitrequest_o !== 1'b0);
    @(posedge core_clk_i);
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task automatic key(input logic [4:0] p);
    @(posedge core_clk_i);
    press <= p;
  endtask
  task automatic chk(input logic [1:0] e);
    repeat (6) @(negedge core_clk_i);
    check({30'h0, irq_o, keypad_irq_o}, {30'h0, e});
  endtask
  task automatic t_reset;
    rd(A_SC, 32'h0);
    rd(A_PE, 32'h0);
    rd(8'h00, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_init;
    bus(1'b1, A_SC, 32'hf2);
    rd(A_SC, 32'h2);
    bus(1'b1, A_PE, 32'hff);
    rd(A_PE, 32'h1f);
    bus(1'b1, A_SC, 32'h6);
    bus(1'b1, A_SC, 32'h0);
    rd(A_SC, 32'h0);
    chk(2'b00);
    $display("test init done");
  endtask
  task automatic t_edge;
    bus(1'b1, A_EE, 32'h1);
    key(5'h01);
    chk(2'b11);
    rd(A_SC, 32'h8);
    bus(1'b1, A_SC, 32'h4);
    chk(2'b10);
    key(5'h03);
    chk(2'b10);
    bus(1'b1, A_EE, 32'h0);
    chk(2'b00);
    bus(1'b1, A_EC, 32'h3);
    rd(A_ES, 32'h0);
    key(5'h00);
    $display("test edge done");
  endtask
  task automatic t_mask;
    bus(1'b1, A_SC, 32'h2);
    key(5'h04);
    chk(2'b00);
    rd(A_SC, 32'ha);
    bus(1'b1, A_SC, 32'h0);
    chk(2'b01);
    @(posedge core_clk_i);
    vf <= 1'b1;
    @(posedge core_clk_i);
    vf <= 1'b0;
    chk(2'b00);
    key(5'h00);
    $display("test mask done");
  endtask
  task automatic t_level;
    bus(1'b1, A_SC, 32'h1);
    rd(A_SC, 32'h1);
    key(5'h08);
    chk(2'b01);
    bus(1'b1, A_SC, 32'h5);
    chk(2'b01);
    key(5'h00);
    chk(2'b00);
    key(5'h08);
    chk(2'b01);
    key(5'h00);
    chk(2'b01);
    bus(1'b1, A_SC, 32'h5);
    chk(2'b00);
    bus(1'b1, A_SC, 32'h0);
    $display("test level done");
  endtask
  task automatic t_break;
    key(5'h10);
    chk(2'b01);
    brk <= 1'b1;
    bus(1'b1, A_SC, 32'h4);
    rd(A_SC, 32'h8);
    bce <= 1'b1;
    bus(1'b1, A_SC, 32'h4);
    brk <= 1'b0;
    bce <= 1'b0;
    rd(A_SC, 32'h0);
    key(5'h00);
    bus(1'b1, A_PE, 32'h1e);
    key(5'h01);
    chk(2'b00);
    key(5'h00);
    $display("test break done");
  endtask
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_init();
    t_edge();
    t_mask();
    t_level();
    t_break();
    tally_and_finish();
  end
endmodule
`default_nettype wire
